// ==== pkg/usc_cfg.svh ====
// Register indices, field positions, reset values and timing counts of the serial core
`ifndef USC_CFG_SVH
`define USC_CFG_SVH
// Register indices; byte address on the bus is four times the index
`define USC_IDX_DATA 8'h20
`define USC_IDX_IER 8'h21
`define USC_IDX_IIR 8'h22
`define USC_IDX_LCR 8'h23
`define USC_IDX_MCR 8'h24
`define USC_IDX_LSR 8'h25
`define USC_IDX_MSR 8'h26
`define USC_IDX_CTL 8'h27
`define USC_IDX_STS 8'h28
`define USC_IDX_PTR 8'h29
`define USC_IDX_CMD 8'h2A
// Reset values
`define USC_BYTE_RST 8'h00
`define USC_DIV_RST 16'h0000
`define USC_DIV_DEFAULT 16'h0040
`define USC_MAP_RST 128'h0
// Line format fields
`define USC_LCR_BANK 7
`define USC_LCR_BRK 6
`define USC_LCR_STICK 5
`define USC_LCR_EVEN 4
`define USC_LCR_PEN 3
`define USC_LCR_STOP 2
// Handshake control fields
`define USC_MCR_LOOP 4
`define USC_MCR_RTS 1
`define USC_MCR_DTR 0
// General control fields
`define USC_CTL_SYNC 0
`define USC_CTL_EXT 1
`define USC_CMD_WR 1
// Interrupt enable fields
`define USC_IER_RXT 0
`define USC_IER_TXT 1
`define USC_IER_LINE 2
`define USC_IER_MODEM 3
`define USC_IER_TO 4
`define USC_IER_SPC 5
`define USC_IER_TSE 6
// Interrupt source codes
`define USC_SRC_MODEM 3'h0
`define USC_SRC_TXT 3'h1
`define USC_SRC_RXT 3'h2
`define USC_SRC_LINE 3'h3
`define USC_SRC_TO 3'h4
`define USC_SRC_TSE 3'h5
// Timing in baud ticks
`define USC_OSR 6'd16
`define USC_HALF 6'd8
`define USC_STOP15 6'd24
`define USC_STOP2 6'd32
`define USC_RX_TO_TICKS 10'd640
`endif

// ==== pkg/usc_pkg.sv ====
// Types shared by the serial core modules
package usc_pkg;
  typedef logic [31:0] usc_word_t;
  typedef logic [7:0]  usc_byte_t;
  typedef enum logic [5:0]
  {
    TX_IDLE  = 6'b000001,
    TX_START = 6'b000010,
    TX_DATA  = 6'b000100,
    TX_PAR   = 6'b001000,
    TX_STOP  = 6'b010000,
    TX_BRK   = 6'b100000
  } usc_tx_t;
  typedef enum logic [4:0]
  {
    RX_IDLE  = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA  = 5'b00100,
    RX_PAR   = 5'b01000,
    RX_STOP  = 5'b10000
  } usc_rx_t;
endpackage

// ==== design/usc_fifo.sv ====
// Small character FIFO with flush
`timescale 1ns/1ps
module usc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire logic          push,
  input  wire logic          pop,
  input  wire logic          flush,
  input  wire logic [W-1:0]  din,
  output logic      [W-1:0]  dout,
  output logic      [AW:0]   count,
  output logic               full,
  output logic               empty
);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          do_push;
  logic          do_pop;

  // Qualified strobes and flags
  assign full    = (cnt_q == (AW+1)'(DEPTH));
  assign empty   = (cnt_q == '0);
  assign do_push = push & ~full & ~flush;
  assign do_pop  = pop & ~empty & ~flush;
  assign dout    = mem[rp_q];
  assign count   = cnt_q;

  // Storage
  always_ff @(posedge clk)
  begin
    if (ce && do_push)
      mem[wp_q] <= din;
  end

  // Pointers and fill level
  always_ff @(posedge clk)
  begin
    if (rst || (ce && flush))
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else if (ce)
    begin
      if (do_push)
        wp_q <= wp_q + 1'b1;
      if (do_pop)
        rp_q <= rp_q + 1'b1;
      if (do_push && !do_pop)
        cnt_q <= cnt_q + 1'b1;
      else if (do_pop && !do_push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // usc_fifo

// ==== design/usc_baud.sv ====
// Baud tick generator dividing the reference enable by a 16-bit divisor
`timescale 1ns/1ps
module usc_baud (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        ref_en,
  input  wire logic        load,
  input  wire logic [15:0] div,
  output logic             tick
);
  logic [15:0] cnt_q;

  // Count reference pulses; divisor one gives a tick on every pulse
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end
    else if (ce)
    begin
      tick <= 1'b0;
      if (load)
        cnt_q <= 16'h0000;
      else if (ref_en)
      begin
        if (cnt_q >= div - 16'h0001)
        begin
          cnt_q <= 16'h0000;
          tick  <= 1'b1;
        end
        else
          cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule // usc_baud

// ==== design/usc_core.sv ====
// Serial core with AHB-Lite register slave, FIFOs, baud generator and line logic
// Overview of operation
// - Five to eight data bits, both directions
// - Even, odd, none, or forced stick parity
// - Stop bits one/two, or one/one-half for five in async
// - Bit rates 300 bit/s to 64 kbit/s
// - Software drives RTS/DTR, reads CTS/DSR levels
// - Async or sync; internal or external clock
// - Software requested break sent on line, async only
// - Four-entry FIFOs with selectable thresholds
// - Threshold reached raises enabled interrupt
// - Up to 128 special codes, 0-127 only
// - Each interrupt source separately enabled
// - Eleven registers 20h-2Ah, 2Bh-3Eh reserved
// - Bank select swaps data/enable with divisor
// - Data read pops oldest received character
// - Written bytes queued, sent LSB first
// - Divisor from readable writable low/high bytes
// - Divisor one passes reference clock undivided
// - Divisor write reloads generator at once
// - Divisor clears; divide by 64 until set
// - Bank select is line control bit 7
// - Length code 00 five to 11 eight
`timescale 1ns/1ps
module usc_core (
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic              CE,
  input  wire logic              HSEL,
  input  wire logic [31:0]       HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire usc_pkg::usc_word_t HWDATA,
  input  wire logic              HREADY,
  output logic                   HREADYOUT,
  output usc_pkg::usc_word_t     HRDATA,
  output logic                   HRESP,
  input  wire logic              RXD,
  output logic                   TXD,
  input  wire logic              CTS_N,
  input  wire logic              DSR_N,
  output logic                   RTS_N,
  output logic                   DTR_N,
  input  wire logic              EXT_CLK,
  output logic                   IRQ
);
  import usc_pkg::*;
  `include "usc_cfg.svh"

  // Serial length from the two low line format bits
  function automatic logic [3:0] nbits(input logic [1:0] code);
    return 4'd5 + {2'b00, code};
  endfunction

  // Keep only the active data bits of a character
  function automatic usc_byte_t mask_len(input logic [1:0] code, input usc_byte_t d);
    return d & (8'hFF >> (2'd3 - code));
  endfunction

  // Parity bit expected for a character under the given line format
  function automatic logic par_bit(input usc_byte_t lcr, input usc_byte_t d);
    if (lcr[`USC_LCR_STICK])
      return ~lcr[`USC_LCR_EVEN];
    return lcr[`USC_LCR_EVEN] ? ^mask_len(lcr[1:0], d) : ~^mask_len(lcr[1:0], d);
  endfunction

  // Register index compare
  function automatic logic at(input logic [7:0] idx, input logic [7:0] off);
    return idx == off;
  endfunction

  logic [3:0]  pin_raw;
  logic [3:0]  s1_q;
  logic [3:0]  s2_q;
  logic        ext_d_q;
  logic        acc_q;
  logic        wr_q;
  logic        hit_q;
  logic [7:0]  idx_q;
  logic        rdy_q;
  usc_word_t   rdata_q;
  usc_byte_t   rd_byte;
  usc_byte_t   wdat;
  logic        wr_en;
  logic        rd_en;
  usc_byte_t   lcr_q;
  usc_byte_t   mcr_q;
  usc_byte_t   ier_q;
  usc_byte_t   ctl_q;
  logic [6:0]  ptr_q;
  logic [15:0] div_q;
  logic        div_set_q;
  logic [127:0] map_q;
  logic        divisor_bank_select;
  logic        sync_m;
  logic        tick;
  logic        div_load;
  logic        tx_push;
  logic        tx_pop;
  logic        tx_flush;
  usc_byte_t   tx_dout;
  logic [2:0]  tx_cnt;
  logic        tx_full;
  logic        tx_empty;
  logic        rx_push;
  logic        rx_pop;
  usc_byte_t   rx_char;
  usc_byte_t   rx_dout;
  logic [2:0]  rx_cnt;
  logic        rx_full;
  logic        rx_empty;
  usc_tx_t     tx_st_q;
  logic [5:0]  tcnt_q;
  logic [2:0]  tbit_q;
  usc_byte_t   tsh_q;
  logic        tpar_q;
  logic        txd_q;
  usc_rx_t     rx_st_q;
  logic [5:0]  rcnt_q;
  logic [2:0]  rbit_q;
  usc_byte_t   rsh_q;
  logic        rpar_q;
  logic        rx_in;
  logic [5:0]  osr;
  logic [5:0]  half;
  logic [5:0]  stop_len;
  logic        brk_req;
  logic        rsamp;
  logic        tdone;
  logic [3:0]  len;
  logic        rdone;
  logic        ev_fe;
  logic        ev_pe;
  logic        ev_brk;
  logic        ev_oe;
  logic        ev_spc;
  logic [7:0]  lsr_q;
  logic        cts_q;
  logic        dsr_q;
  logic [1:0]  dlt_q;
  logic [9:0]  to_cnt_q;
  logic        to_q;
  logic        rx_thr;
  logic        tx_thr;
  logic        tse;
  logic        rx_thr_q;
  logic        tx_thr_q;
  logic        tse_d_q;
  logic        rxt_ip_q;
  logic        txt_ip_q;
  logic        tse_ip_q;
  logic [2:0]  src;
  logic        pend;
  logic        irq_q;
  logic        txo_q;
  logic        rts_n_q;
  logic        dtr_n_q;

  // Two-flop synchronisers for every asynchronous pin
  assign pin_raw = {EXT_CLK, DSR_N, CTS_N, RXD};
  for (genvar i = 0; i < 4; i++)
  begin : g_sync
    always_ff @(posedge CLK)
    begin
      if (RST)
      begin
        s1_q[i] <= 1'b1;
        s2_q[i] <= 1'b1;
      end
      else if (CE)
      begin
        s1_q[i] <= pin_raw[i];
        s2_q[i] <= s1_q[i];
      end
    end
  end

  // AHB-Lite slave: one wait state, registered read data
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      acc_q   <= 1'b0;
      wr_q    <= 1'b0;
      hit_q   <= 1'b0;
      idx_q   <= 8'h00;
      rdy_q   <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    else if (CE)
    begin
      if (HSEL && HREADY && HTRANS[1])
      begin
        acc_q <= 1'b1;
        wr_q  <= HWRITE;
        hit_q <= (HADDR[31:10] == 22'h0) && (HADDR[1:0] == 2'h0);
        idx_q <= HADDR[9:2];
        rdy_q <= 1'b0;
      end
      else if (acc_q)
      begin
        acc_q   <= 1'b0;
        rdy_q   <= 1'b1;
        rdata_q <= wr_q ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      end
    end
  end
  assign HREADYOUT = rdy_q;
  assign HRDATA    = rdata_q;
  assign HRESP     = 1'b0;

  // Access strobes; indices outside 20h-2Ah read zero and ignore writes
  assign wdat   = HWDATA[7:0];
  assign wr_en  = acc_q & wr_q & hit_q & CE;
  assign rd_en  = acc_q & ~wr_q & hit_q & CE;
  assign divisor_bank_select = lcr_q[`USC_LCR_BANK];
  assign sync_m = ctl_q[`USC_CTL_SYNC];
  assign tx_push  = wr_en & at(idx_q, `USC_IDX_DATA) & ~divisor_bank_select;
  assign rx_pop   = rd_en & at(idx_q, `USC_IDX_DATA) & ~divisor_bank_select;
  assign div_load = wr_en & ~divisor_bank_select ? 1'b0 :
                    wr_en & (at(idx_q, `USC_IDX_DATA) | at(idx_q, `USC_IDX_IER));

  // Software written control registers
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      lcr_q     <= `USC_BYTE_RST;
      mcr_q     <= `USC_BYTE_RST;
      ier_q     <= `USC_BYTE_RST;
      ctl_q     <= `USC_BYTE_RST;
      ptr_q     <= 7'h00;
      div_q     <= `USC_DIV_RST;
      div_set_q <= 1'b0;
      map_q     <= `USC_MAP_RST;
    end
    else if (wr_en)
    begin
      if (at(idx_q, `USC_IDX_DATA) && divisor_bank_select)
      begin
        div_q[7:0] <= wdat;
        div_set_q  <= 1'b1;
      end
      if (at(idx_q, `USC_IDX_IER) && divisor_bank_select)
      begin
        div_q[15:8] <= wdat;
        div_set_q   <= 1'b1;
      end
      if (at(idx_q, `USC_IDX_IER) && !divisor_bank_select)
        ier_q <= {1'b0, wdat[6:0]};
      if (at(idx_q, `USC_IDX_LCR))
        lcr_q <= wdat;
      if (at(idx_q, `USC_IDX_MCR))
        mcr_q <= {3'h0, wdat[4], 2'h0, wdat[1:0]};
      if (at(idx_q, `USC_IDX_CTL))
        ctl_q <= {2'h0, wdat[5:0]};
      if (at(idx_q, `USC_IDX_PTR))
        ptr_q <= wdat[6:0];
      if (at(idx_q, `USC_IDX_CMD) && wdat[`USC_CMD_WR])
        map_q[ptr_q] <= wdat[0];
    end
  end

  // Baud generator on the core clock or on external clock edges
  always_ff @(posedge CLK)
  begin
    if (RST)
      ext_d_q <= 1'b1; // Matches the synchroniser reset level, no false edge
    else if (CE)
      ext_d_q <= s2_q[3];
  end
  usc_baud u_baud (
    .clk    (CLK),
    .rst    (RST),
    .ce     (CE),
    .ref_en (ctl_q[`USC_CTL_EXT] ? (s2_q[3] & ~ext_d_q) : 1'b1),
    .load   (div_load),
    .div    (div_set_q ? div_q : `USC_DIV_DEFAULT),
    .tick   (tick)
  );

  // Character FIFOs
  usc_fifo #(.W(8), .DEPTH(4), .AW(2)) u_txf (
    .clk   (CLK),
    .rst   (RST),
    .ce    (CE),
    .push  (tx_push),
    .pop   (tx_pop),
    .flush (tx_flush),
    .din   (wdat),
    .dout  (tx_dout),
    .count (tx_cnt),
    .full  (tx_full),
    .empty (tx_empty)
  );
  usc_fifo #(.W(8), .DEPTH(4), .AW(2)) u_rxf (
    .clk   (CLK),
    .rst   (RST),
    .ce    (CE),
    .push  (rx_push),
    .pop   (rx_pop),
    .flush (1'b0),
    .din   (rx_char),
    .dout  (rx_dout),
    .count (rx_cnt),
    .full  (rx_full),
    .empty (rx_empty)
  );

  // Bit timing: sixteen ticks a bit async, one tick a bit sync
  assign len      = nbits(lcr_q[1:0]);
  assign osr      = sync_m ? 6'd1 : `USC_OSR;
  assign half     = sync_m ? 6'd1 : `USC_HALF;
  assign stop_len = !lcr_q[`USC_LCR_STOP] ? osr :
                    sync_m ? 6'd2 :
                    (lcr_q[1:0] == 2'b00) ? `USC_STOP15 : `USC_STOP2;
  assign brk_req  = lcr_q[`USC_LCR_BRK] & ~sync_m;
  assign tdone    = tick & (tcnt_q == ((tx_st_q == TX_STOP) ? stop_len : osr) - 6'd1);
  assign tx_pop   = tick & (tx_st_q == TX_IDLE) & ~brk_req & ~tx_empty;
  assign tx_flush = (tx_st_q == TX_BRK);

  // Transmit sequencer
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      tx_st_q <= TX_IDLE;
      tcnt_q  <= 6'd0;
      tbit_q  <= 3'd0;
      tsh_q   <= 8'h00;
      tpar_q  <= 1'b0;
      txd_q   <= 1'b1;
    end
    else if (CE && tick)
    begin
      tcnt_q <= tdone ? 6'd0 : tcnt_q + 6'd1;
      case (tx_st_q)
        TX_IDLE:
        begin
          tcnt_q <= 6'd0;
          if (brk_req)
          begin
            tx_st_q <= TX_BRK;
            txd_q   <= 1'b0;
          end
          else if (!tx_empty)
          begin
            tx_st_q <= TX_START;
            tsh_q   <= tx_dout;
            tpar_q  <= par_bit(lcr_q, tx_dout);
            txd_q   <= 1'b0;
          end
        end
        TX_START:
          if (tdone)
          begin
            tx_st_q <= TX_DATA;
            tbit_q  <= 3'd0;
            txd_q   <= tsh_q[0];
          end
        TX_DATA:
          if (tdone)
          begin
            tsh_q  <= tsh_q >> 1;
            tbit_q <= tbit_q + 3'd1;
            if ({1'b0, tbit_q} == len - 4'd1)
            begin
              tx_st_q <= lcr_q[`USC_LCR_PEN] ? TX_PAR : TX_STOP;
              txd_q   <= lcr_q[`USC_LCR_PEN] ? tpar_q : 1'b1;
            end
            else
              txd_q <= tsh_q[1];
          end
        TX_PAR:
          if (tdone)
          begin
            tx_st_q <= TX_STOP;
            txd_q   <= 1'b1;
          end
        TX_STOP:
          if (tdone)
            tx_st_q <= TX_IDLE;
        TX_BRK:
        begin
          tcnt_q <= 6'd0;
          if (!brk_req)
          begin
            tx_st_q <= TX_STOP;
            txd_q   <= 1'b1;
          end
        end
        default:
        begin
          tx_st_q <= TX_IDLE;
          txd_q   <= 1'b1;
        end
      endcase
    end
  end

  // Receive path, looped to the transmitter in local loopback
  assign rx_in   = mcr_q[`USC_MCR_LOOP] ? txd_q : s2_q[0];
  assign rsamp   = tick & (rcnt_q == osr - 6'd1);
  assign rdone   = (rx_st_q == RX_STOP) & rsamp;
  assign rx_char = rsh_q >> (4'd8 - len);
  assign rx_push = rdone;
  assign ev_fe   = rdone & ~rx_in;
  assign ev_pe   = rdone & lcr_q[`USC_LCR_PEN] & (rpar_q != par_bit(lcr_q, rx_char));
  assign ev_brk  = ev_fe & (rx_char == 8'h00) & ~(lcr_q[`USC_LCR_PEN] & rpar_q);
  assign ev_oe   = rdone & rx_full;
  assign ev_spc  = rdone & ~rx_full & ~rx_char[7] & map_q[rx_char[6:0]];

  // Receive sequencer
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      rx_st_q <= RX_IDLE;
      rcnt_q  <= 6'd0;
      rbit_q  <= 3'd0;
      rsh_q   <= 8'h00;
      rpar_q  <= 1'b0;
    end
    else if (CE && tick)
    begin
      rcnt_q <= rsamp ? 6'd0 : rcnt_q + 6'd1;
      case (rx_st_q)
        RX_IDLE:
        begin
          rcnt_q <= 6'd0;
          if (!rx_in)
            rx_st_q <= RX_START;
        end
        RX_START:
          if (rcnt_q == half - 6'd1)
          begin
            rcnt_q  <= 6'd0;
            rbit_q  <= 3'd0;
            rx_st_q <= rx_in ? RX_IDLE : RX_DATA;
          end
        RX_DATA:
          if (rsamp)
          begin
            rsh_q  <= {rx_in, rsh_q[7:1]};
            rbit_q <= rbit_q + 3'd1;
            if ({1'b0, rbit_q} == len - 4'd1)
              rx_st_q <= lcr_q[`USC_LCR_PEN] ? RX_PAR : RX_STOP;
          end
        RX_PAR:
          if (rsamp)
          begin
            rpar_q  <= rx_in;
            rx_st_q <= RX_STOP;
          end
        RX_STOP:
          if (rsamp)
            rx_st_q <= RX_IDLE;
        default:
          rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // Sticky line flags; a new event wins over the clear by a status read
  always_ff @(posedge CLK)
  begin
    if (RST)
      lsr_q <= 8'h00;
    else if (CE)
    begin
      lsr_q <= (rd_en && at(idx_q, `USC_IDX_LSR)) ? 8'h00 : lsr_q;
      if (ev_spc) lsr_q[7] <= 1'b1;
      if (ev_brk) lsr_q[4] <= 1'b1;
      if (ev_fe)  lsr_q[3] <= 1'b1;
      if (ev_pe)  lsr_q[2] <= 1'b1;
      if (ev_oe)  lsr_q[1] <= 1'b1;
    end
  end

  // Handshake pin levels, change flags and output drive
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      cts_q   <= 1'b0;
      dsr_q   <= 1'b0;
      dlt_q   <= 2'b00;
      rts_n_q <= 1'b1;
      dtr_n_q <= 1'b1;
    end
    else if (CE)
    begin
      cts_q   <= ~s2_q[1];
      dsr_q   <= ~s2_q[2];
      rts_n_q <= ~mcr_q[`USC_MCR_RTS];
      dtr_n_q <= ~mcr_q[`USC_MCR_DTR];
      dlt_q   <= (rd_en && at(idx_q, `USC_IDX_MSR)) ? 2'b00 : dlt_q;
      if (cts_q != ~s2_q[1]) dlt_q[0] <= 1'b1;
      if (dsr_q != ~s2_q[2]) dlt_q[1] <= 1'b1;
    end
  end

  // Receive timeout: characters waiting and line quiet for 640 ticks, four ten-bit frames in async
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      to_cnt_q <= 10'd0;
      to_q     <= 1'b0;
    end
    else if (CE)
    begin
      if (rx_empty || rx_pop || rx_st_q != RX_IDLE)
        to_cnt_q <= 10'd0;
      else if (tick && to_cnt_q != `USC_RX_TO_TICKS)
        to_cnt_q <= to_cnt_q + 10'd1;
      to_q <= (rd_en && at(idx_q, `USC_IDX_STS)) ? 1'b0 : to_q;
      if (tick && to_cnt_q == `USC_RX_TO_TICKS - 10'd1)
        to_q <= 1'b1;
    end
  end

  // Threshold and shift-empty conditions, latched on their rising edge
  assign rx_thr = rx_cnt >= ({1'b0, ctl_q[3:2]} + 3'd1);
  assign tx_thr = tx_cnt <= ({1'b0, ctl_q[5:4]} + 3'd1);
  assign tse    = (tx_st_q == TX_IDLE) & tx_empty;
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      rx_thr_q <= 1'b0;
      tx_thr_q <= 1'b0;
      tse_d_q  <= 1'b0;
      rxt_ip_q <= 1'b0;
      txt_ip_q <= 1'b0;
      tse_ip_q <= 1'b0;
      irq_q    <= 1'b0;
    end
    else if (CE)
    begin
      rx_thr_q <= rx_thr;
      tx_thr_q <= tx_thr;
      tse_d_q  <= tse;
      if (rx_thr & ~rx_thr_q)
        rxt_ip_q <= 1'b1;
      else if (rd_en && at(idx_q, `USC_IDX_IIR) && pend && src == `USC_SRC_RXT)
        rxt_ip_q <= 1'b0;
      if (tx_thr & ~tx_thr_q)
        txt_ip_q <= 1'b1;
      else if (rd_en && at(idx_q, `USC_IDX_IIR) && pend && src == `USC_SRC_TXT)
        txt_ip_q <= 1'b0;
      if (tse & ~tse_d_q)
        tse_ip_q <= 1'b1;
      else if (rd_en && at(idx_q, `USC_IDX_IIR) && pend && src == `USC_SRC_TSE)
        tse_ip_q <= 1'b0;
      irq_q <= pend;
    end
  end

  // Highest priority enabled source
  always_comb
  begin
    pend = 1'b1;
    src  = `USC_SRC_MODEM;
    if ((ier_q[`USC_IER_LINE] && |lsr_q[4:1]) || (ier_q[`USC_IER_SPC] && lsr_q[7]))
      src = `USC_SRC_LINE;
    else if (ier_q[`USC_IER_RXT] && rxt_ip_q)
      src = `USC_SRC_RXT;
    else if (ier_q[`USC_IER_TXT] && txt_ip_q)
      src = `USC_SRC_TXT;
    else if (ier_q[`USC_IER_MODEM] && |dlt_q)
      src = `USC_SRC_MODEM;
    else if (ier_q[`USC_IER_TO] && to_q)
      src = `USC_SRC_TO;
    else if (ier_q[`USC_IER_TSE] && tse_ip_q)
      src = `USC_SRC_TSE;
    else
      pend = 1'b0;
  end

  // Read data selection
  always_comb
  begin
    rd_byte = 8'h00;
    case (idx_q)
      `USC_IDX_DATA: rd_byte = divisor_bank_select ? div_q[7:0] : rx_dout;
      `USC_IDX_IER:  rd_byte = divisor_bank_select ? div_q[15:8] : ier_q;
      `USC_IDX_IIR:  rd_byte = {4'h0, src, ~pend};
      `USC_IDX_LCR:  rd_byte = lcr_q;
      `USC_IDX_MCR:  rd_byte = mcr_q;
      `USC_IDX_LSR:  rd_byte = {lsr_q[7], tse, tx_thr, lsr_q[4:1], ~rx_empty};
      `USC_IDX_MSR:  rd_byte = {2'h0, dsr_q, cts_q, 2'h0, dlt_q};
      `USC_IDX_CTL:  rd_byte = ctl_q;
      `USC_IDX_STS:  rd_byte = {tx_cnt, rx_cnt, 1'b0, to_q};
      `USC_IDX_PTR:  rd_byte = {1'b0, ptr_q};
      `USC_IDX_CMD:  rd_byte = {7'h00, map_q[ptr_q]};
      default:       rd_byte = 8'h00;
    endcase
  end

  // Registered pins; line held marking during loopback
  always_ff @(posedge CLK)
  begin
    if (RST)
      txo_q <= 1'b1;
    else if (CE)
      txo_q <= mcr_q[`USC_MCR_LOOP] ? 1'b1 : txd_q;
  end
  assign TXD   = txo_q;
  assign RTS_N = rts_n_q;
  assign DTR_N = dtr_n_q;
  assign IRQ   = irq_q;
endmodule // usc_core

// ==== tb/usc_core_properties.sv ====
// Bus and pin assertions for the serial core
`timescale 1ns/1ps
module usc_core_properties
  import usc_pkg::*;
(
  input logic       CLK,
  input logic       RST,
  input logic       CE,
  input logic       HSEL,
  input logic [1:0] HTRANS,
  input logic       HREADY,
  input logic       HREADYOUT,
  input usc_word_t  HRDATA,
  input logic       HRESP,
  input logic       TXD,
  input logic       RTS_N,
  input logic       DTR_N,
  input logic       IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Bus timing, data and pin behaviour
  a_resp_okay: assert property (HRESP == 1'b0) else $error("bad resp");
  a_wait_one: assert property ((CE && HSEL && HREADY && HTRANS[1]) |=> !HREADYOUT)
    else $error("no wait state");
  a_ready_back: assert property ((CE && !HREADYOUT) |=> HREADYOUT)
    else $error("long wait");
  a_idle_ready: assert property ((CE && HREADYOUT && !(HSEL && HREADY && HTRANS[1]))
    |=> HREADYOUT) else $error("spurious wait");
  a_rdata_upper: assert property (HRDATA[31:8] == 24'h0) else $error("upper data");
  a_rdata_hold: assert property ((HREADYOUT && $past(HREADYOUT)) |-> $stable(HRDATA))
    else $error("data moved");
  a_rts_write: assert property ($changed(RTS_N) |->
    (!$past(HREADYOUT) || !$past(HREADYOUT, 2))) else $error("rts moved");
  a_dtr_write: assert property ($changed(DTR_N) |->
    (!$past(HREADYOUT) || !$past(HREADYOUT, 2))) else $error("dtr moved");
  a_reset_idle: assert property ($fell(RST) |-> (TXD && RTS_N && DTR_N && !IRQ))
    else $error("not idle");
endmodule // usc_core_properties

bind usc_core usc_core_properties usc_core_properties_inst (.CLK, .RST, .CE, .HSEL,
  .HTRANS, .HREADY, .HREADYOUT, .HRDATA, .HRESP, .TXD, .RTS_N, .DTR_N, .IRQ);

// ==== tb/usc_term.sv ====
// Remote terminal model on the serial line
`timescale 1ns/1ps
module usc_term (
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);
  int         bp = 1024;
  int         nb = 8;
  logic [7:0] got;
  event       done;
  initial rxd = 1'b1;
  // Sample each bit at its middle, low bit first
  always
  begin
    @(negedge txd);
    got = 8'h00;
    repeat (bp / 2) @(posedge clk);
    for (int i = 0; i < nb; i++)
    begin
      repeat (bp) @(posedge clk);
      got[i] = txd;
    end
    repeat (bp) @(posedge clk);
    -> done;
  end
  // Start, data low bit first, stop; line rests high
  task send(logic [7:0] d);
    for (int i = -1; i <= nb; i++)
    begin
      @(posedge clk);
      rxd <= (i < 0) ? 1'b0 : (i == nb) ? 1'b1 : d[i];
      repeat (bp - 1) @(posedge clk);
    end
  endtask
endmodule // usc_term

// ==== tb/testbench.sv ====
// Bench driving the serial core over the bus and the line
`timescale 1ns/1ps
module testbench;
  import usc_pkg::*;
  logic       CLK, RST, CTS_N, DSR_N, HWRITE, rdf;
  logic [1:0] HTRANS;
  usc_word_t  HADDR, HWDATA, HRDATA;
  wire        HREADY, TXD, RXD, RTS_N, DTR_N, IRQ;
  logic [1:0] ediv;
  wire        EXT_CLK = ediv[1];
  logic [7:0] b, eq[$], tq[$];
  int         error_cnt, n_compared, cyc;
  usc_core usc_core_inst (.CLK, .RST, .CE(1'b1), .HSEL(1'b1), .HADDR, .HTRANS, .HWRITE,
    .HSIZE(3'h2), .HWDATA, .HREADY, .HREADYOUT(HREADY), .HRDATA, .HRESP(), .RXD, .TXD,
    .CTS_N, .DSR_N, .RTS_N, .DTR_N, .EXT_CLK, .IRQ);
  // External serial reference, one rising edge every four clocks
  always @(posedge CLK) ediv <= ediv + 2'h1;
  usc_term usc_term_inst (.clk(CLK), .txd(TXD), .rxd(RXD));
  task chk(string n, logic [7:0] s, e);
    n_compared++;
    if (s !== e)
    begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  // One single transfer; address held until ready, then data phase
  task bus(logic w, logic [7:0] a, d);
    HADDR <= {22'h0, a, 2'h0};
    HTRANS <= 2'h2;
    HWRITE <= w;
    do @(posedge CLK); while (HREADY !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= {24'h0, d};
    do @(posedge CLK); while (HREADY !== 1'b1);
    rdf = !w;
  endtask
  task rd(logic [7:0] a, e); eq.push_back(e); bus(1'b0, a, 8'h00); endtask
  task wr(logic [7:0] a, d); bus(1'b1, a, d); endtask
  // Compare results against the oldest note
  always @(negedge CLK)
    if (rdf)
    begin
      rdf = 1'b0;
      chk("rdata", HRDATA[7:0], eq.pop_front());
    end
  always @(usc_term_inst.done) chk("line", usc_term_inst.got, tq.pop_front());
  initial
  begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  // Hang guard
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      error_cnt++;
      results();
    end
  end
  initial
  begin
    {RST, CTS_N, DSR_N} = 3'h7;
    {HADDR, HWDATA, HTRANS, HWRITE, rdf, ediv} = '0;
    void'($urandom(32'h4ec6));
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    rd(8'h22, 8'h01);
    wr(8'h23, 8'h80);
    rd(8'h20, 8'h00);
    rd(8'h21, 8'h00);
    wr(8'h20, 8'h01);
    wr(8'h21, 8'h00);
    rd(8'h20, 8'h01);
    usc_term_inst.bp = 16;
    for (int l = 0; l < 4; l++)
    begin
      b = 8'($urandom) & (8'hFF >> (3 - l));
      usc_term_inst.nb = 5 + l;
      wr(8'h23, 8'(l));
      tq.push_back(b);
      wr(8'h20, b);
      @(usc_term_inst.done);
      usc_term_inst.send(b);
      repeat (40) @(posedge CLK);
      rd(8'h20, b);
    end
    b = 8'($urandom);
    wr(8'h27, 8'h02);
    usc_term_inst.bp = 64;
    tq.push_back(b);
    wr(8'h20, b);
    @(usc_term_inst.done);
    wr(8'h24, 8'h03);
    CTS_N <= 1'b0;
    repeat (6) @(posedge CLK);
    chk("rts dtr", {6'h0, RTS_N, DTR_N}, 8'h00);
    wr(8'h21, 8'h08);
    rd(8'h22, 8'h00);
    chk("irq", {7'h0, IRQ}, 8'h01);
    rd(8'h26, 8'h11);
    repeat (2) @(posedge CLK);
    chk("irq", {7'h0, IRQ}, 8'h00);
    rd(8'h2B, 8'h00);
    repeat (4) @(posedge CLK);
    results();
  end
  task results;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
endmodule // testbench
